/* common/emio_link_if.sv */
// One expansion connector between host board and module
`timescale 1ns/100ps
`default_nettype none
interface emio_link_if;
    logic        mclk;
    logic        mreset;
    logic [2:0]  addrLines;
    logic [1:0]  select_n;
    logic        readCmd_n;
    logic        writeCmd_n;
    logic [15:0] hostData;
    logic        hostDataOe_n;
    logic [15:0] modData;
    logic [1:0]  modDataOe_n;
    logic        waitReq_n;
    logic        present_n;
    logic [1:0]  moduleIrq;
    logic [1:0]  optionLine;
    logic [15:0] dataBus;

    // Resolved level of the data lines, per byte lane
    always_comb begin
        dataBus = 16'hFFFF;
        if (!hostDataOe_n) begin
            dataBus = hostData;
        end
        if (!modDataOe_n[0]) begin
            dataBus[7:0] = modData[7:0];
        end
        if (!modDataOe_n[1]) begin
            dataBus[15:8] = modData[15:8];
        end
    end

    modport host (
        output mclk, mreset, addrLines, select_n, readCmd_n, writeCmd_n,
        output hostData, hostDataOe_n,
        input  dataBus, waitReq_n, present_n, moduleIrq, optionLine
    );
    modport module_end (
        input  mclk, mreset, addrLines, select_n, readCmd_n, writeCmd_n,
        input  dataBus,
        output modData, modDataOe_n, waitReq_n, present_n, moduleIrq, optionLine
    );
endinterface
`default_nettype wire

/* common/emio_params.svh */
// Constants of the expansion module I/O port, both ends
// Operation
// [RULE_01] Second connector select0: even 80h-8Fh
// [RULE_02] First connector select0: even A0h-AFh
// [RULE_03] Second connector select1: even 90h-9Fh, 8-bit
// [RULE_04] Second connector select1: odd 80h-8Fh, 16-bit
// [RULE_05] First connector select1: even 80h-8Fh, 8-bit
// [RULE_06] First connector select1: odd A0h-AFh, 16-bit
// [RULE_07] Address lines carry CPU bits 1..3 only
// [RULE_08] Read/write commands strobe selected module
// [RULE_09] Module reset drives module to known state
// [RULE_10] Fitted module pulls present line low
// [RULE_11] Two module interrupt lines reach matrix
// [RULE_12] Wait request stretches access until ready
// [RULE_13] Continuous module clock near 9.22 MHz; the divider gives 10 MHz from the 40 MHz system clock
// [RULE_14] Option lines usable as extra interrupts
// [RULE_15] Sixteen data lines; 8-bit uses low byte
// [RULE_16] Host drives on write; module on read+select
`ifndef EMIO_PARAMS_SVH
`define EMIO_PARAMS_SVH

// ****************************************
// Decode windows (upper nibble of port)
// ****************************************
`define EMIO_C2_SEL0_HI    4'h8
`define EMIO_C2_SEL1_HI    4'h9
`define EMIO_C1_SEL0_HI    4'hA
`define EMIO_C1_SEL1_8B_HI 4'h8

// ****************************************
// Timing
// ****************************************
`define EMIO_SYS_KHZ       40000
`define EMIO_MCLK_KHZ      9220
`define EMIO_MCLK_HALF     (`EMIO_SYS_KHZ / (2 * `EMIO_MCLK_KHZ))
`define EMIO_CMD_MIN_NS    500
`define EMIO_CMD_MIN_CYC   ((`EMIO_CMD_MIN_NS * `EMIO_SYS_KHZ + 999999) / 1000000)
`define EMIO_MRESET_NS     2000
`define EMIO_MRESET_CYC    ((`EMIO_MRESET_NS * `EMIO_SYS_KHZ + 999999) / 1000000)
`define EMIO_WAIT_LAT      4
// Module clock periods of idle bus after a command, so modules see the gap
`define EMIO_RECOVER_MCLK  4
`define EMIO_CNT_W         8

`endif

/* common/emio_pkg.sv */
// Types of the expansion module I/O port
package emio_pkg;
    typedef enum logic [1:0] {
        EMIO_IDLE  = 2'b00,
        EMIO_SETUP = 2'b01,
        EMIO_CMD   = 2'b11,
        EMIO_HOLD  = 2'b10
    } emio_state_t;
    typedef logic [1:0] emio_sel_t;
endpackage

/* hdl/emio_host_end.sv */
// Host board end: two expansion connectors behind the CPU I/O port
`timescale 1ns/100ps
`default_nettype none
`include "emio_params.svh"
module emio_host_end #(
    parameter int CMD_MIN_CYC = `EMIO_CMD_MIN_CYC,
    parameter int MRESET_CYC  = `EMIO_MRESET_CYC,
    parameter int MCLK_HALF   = `EMIO_MCLK_HALF
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        cpuReq,
    input  wire logic        cpuWrite,
    input  wire logic [7:0]  cpuAddr,
    input  wire logic [15:0] cpuWdata,
    input  wire logic [1:0]  connWide,
    input  wire logic [1:0]  optIrqEn,
    output logic             cpuBusy,
    output logic             cpuAck,
    output logic             cpuMiss,
    output logic      [15:0] cpuRdata,
    output logic      [7:0]  irqMatrix,
    output logic      [1:0]  modulePresent,
    emio_link_if.host        link1,
    emio_link_if.host        link2
);
    // ****************************************
    // Chip select decode
    // ****************************************
    // Index 0 is the first connector, index 1 the second
    function automatic emio_pkg::emio_sel_t decode(
        input logic [7:0] addr,
        input logic       conn,
        input logic       wide
    );
        logic [3:0] hi;
        logic       even;
        hi   = addr[7:4];
        even = ~addr[0];
        decode = 2'b00;
        if (conn) begin
            decode[0] = even && hi == `EMIO_C2_SEL0_HI; // [RULE_01]
            if (wide) begin
                decode[1] = !even && hi == `EMIO_C2_SEL0_HI; // [RULE_04]
            end else begin
                decode[1] = even && hi == `EMIO_C2_SEL1_HI; // [RULE_03]
            end
        end else begin
            decode[0] = even && hi == `EMIO_C1_SEL0_HI; // [RULE_02]
            if (wide) begin
                decode[1] = !even && hi == `EMIO_C1_SEL0_HI; // [RULE_06]
            end else begin
                decode[1] = even && hi == `EMIO_C1_SEL1_8B_HI; // [RULE_05]
            end
        end
    endfunction

    // ****************************************
    // Module clock divider
    // ****************************************
    logic [`EMIO_CNT_W-1:0] divCnt;
    logic                   mclk;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divCnt <= '0;
            mclk   <= 1'b0;
        end else if (divCnt == `EMIO_CNT_W'(MCLK_HALF - 1)) begin
            divCnt <= '0;
            mclk   <= ~mclk; // [RULE_13]
        end else begin
            divCnt <= divCnt + 1'b1;
        end
    end

    // ****************************************
    // Module reset stretch
    // ****************************************
    logic [`EMIO_CNT_W-1:0] rstCnt;
    logic                   mreset;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstCnt <= '0;
            mreset <= 1'b1;
        end else if (rstCnt != `EMIO_CNT_W'(MRESET_CYC)) begin
            rstCnt <= rstCnt + 1'b1;
        end else begin
            mreset <= 1'b0; // [RULE_09]
        end
    end

    // ****************************************
    // Input synchronisers, both connectors
    // ****************************************
    logic [21:0] rawIn [0:1];
    logic [21:0] syncA [0:1];
    logic [21:0] syncB [0:1];
    assign rawIn[0] = {link1.waitReq_n, link1.present_n, link1.moduleIrq,
                       link1.optionLine, link1.dataBus};
    assign rawIn[1] = {link2.waitReq_n, link2.present_n, link2.moduleIrq,
                       link2.optionLine, link2.dataBus};
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            syncA[0] <= {2'b11, 20'h00000};
            syncA[1] <= {2'b11, 20'h00000};
            syncB[0] <= {2'b11, 20'h00000};
            syncB[1] <= {2'b11, 20'h00000};
        end else begin
            syncA[0] <= rawIn[0];
            syncA[1] <= rawIn[1];
            syncB[0] <= syncA[0];
            syncB[1] <= syncA[1];
        end
    end

    // ****************************************
    // Interrupt routing and presence
    // ****************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqMatrix     <= 8'h00;
            modulePresent <= 2'b00;
        end else begin
            irqMatrix <= {syncB[1][17:16] & {2{optIrqEn[1]}}, syncB[1][19:18], // [RULE_14]
                          syncB[0][17:16] & {2{optIrqEn[0]}}, syncB[0][19:18]}; // [RULE_11]
            modulePresent <= {~syncB[1][20], ~syncB[0][20]}; // [RULE_10]
        end
    end

    // ****************************************
    // Access sequencer
    // ****************************************
    emio_pkg::emio_state_t  state;
    logic [`EMIO_CNT_W-1:0] cmdCnt;
    logic                   isWrite;
    logic [2:0]             addrLines;
    logic [15:0]            wdata;
    emio_pkg::emio_sel_t    sel [0:1];
    logic                   waitAny;
    assign waitAny = (|sel[0] && !syncB[0][21]) || (|sel[1] && !syncB[1][21]);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state     <= emio_pkg::EMIO_IDLE;
            cmdCnt    <= '0;
            isWrite   <= 1'b0;
            addrLines <= 3'h0;
            wdata     <= 16'h0000;
            sel[0]    <= 2'b00;
            sel[1]    <= 2'b00;
            cpuBusy   <= 1'b0;
            cpuAck    <= 1'b0;
            cpuMiss   <= 1'b0;
            cpuRdata  <= 16'h0000;
        end else begin
            cpuAck  <= 1'b0;
            cpuMiss <= 1'b0;
            case (state)
                emio_pkg::EMIO_IDLE: begin
                    if (cpuReq && !mreset) begin
                        if (|decode(cpuAddr, 1'b0, connWide[0])
                                || |decode(cpuAddr, 1'b1, connWide[1])) begin
                            sel[0]    <= decode(cpuAddr, 1'b0, connWide[0]);
                            sel[1]    <= decode(cpuAddr, 1'b1, connWide[1]);
                            addrLines <= cpuAddr[3:1]; // [RULE_07]
                            isWrite   <= cpuWrite;
                            wdata     <= cpuWdata;
                            cpuBusy   <= 1'b1;
                            state     <= emio_pkg::EMIO_SETUP;
                        end else begin
                            cpuMiss <= 1'b1;
                            cpuAck  <= 1'b1;
                        end
                    end
                end
                emio_pkg::EMIO_SETUP: begin
                    cmdCnt <= `EMIO_CNT_W'(CMD_MIN_CYC);
                    state  <= emio_pkg::EMIO_CMD; // [RULE_08]
                end
                emio_pkg::EMIO_CMD: begin
                    if (cmdCnt != '0) begin
                        cmdCnt <= cmdCnt - 1'b1;
                    end else if (!waitAny) begin
                        state  <= emio_pkg::EMIO_HOLD; // [RULE_12]
                        cmdCnt <= `EMIO_CNT_W'(`EMIO_RECOVER_MCLK * 2 * MCLK_HALF);
                        if (!isWrite) begin
                            cpuRdata <= (|sel[1]) ? syncB[1][15:0] : syncB[0][15:0];
                        end
                    end
                end
                emio_pkg::EMIO_HOLD: begin
                    sel[0] <= 2'b00;
                    sel[1] <= 2'b00;
                    if (cmdCnt != '0) begin
                        cmdCnt <= cmdCnt - 1'b1;
                    end else begin
                        cpuBusy <= 1'b0;
                        cpuAck  <= 1'b1;
                        state   <= emio_pkg::EMIO_IDLE;
                    end
                end
                default: begin
                    state <= emio_pkg::EMIO_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Link pin registers
    // ****************************************
    logic [1:0] selOut_n [0:1];
    logic [1:0] readCmd_n;
    logic [1:0] writeCmd_n;
    logic [1:0] dataOe_n;
    logic [1:0] selAny;
    logic       inCmd;
    assign selAny = {|sel[1], |sel[0]};
    assign inCmd = (state == emio_pkg::EMIO_SETUP) || (state == emio_pkg::EMIO_CMD
                   && (cmdCnt != '0 || waitAny));
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            selOut_n[0] <= 2'b11;
            selOut_n[1] <= 2'b11;
            readCmd_n   <= 2'b11;
            writeCmd_n  <= 2'b11;
            dataOe_n    <= 2'b11;
        end else begin
            selOut_n[0] <= ~sel[0];
            selOut_n[1] <= ~sel[1];
            readCmd_n   <= ~(selAny & {2{inCmd && !isWrite}}); // [RULE_08]
            writeCmd_n  <= ~(selAny & {2{inCmd && isWrite}});
            dataOe_n    <= ~(selAny & {2{inCmd && isWrite}}); // [RULE_16] [RULE_15]
        end
    end

    assign link1.mclk         = mclk;
    assign link1.mreset       = mreset;
    assign link1.addrLines    = addrLines;
    assign link1.select_n     = selOut_n[0];
    assign link1.readCmd_n    = readCmd_n[0];
    assign link1.writeCmd_n   = writeCmd_n[0];
    assign link1.hostData     = wdata;
    assign link1.hostDataOe_n = dataOe_n[0];
    assign link2.mclk         = mclk;
    assign link2.mreset       = mreset;
    assign link2.addrLines    = addrLines;
    assign link2.select_n     = selOut_n[1];
    assign link2.readCmd_n    = readCmd_n[1];
    assign link2.writeCmd_n   = writeCmd_n[1];
    assign link2.hostData     = wdata;
    assign link2.hostDataOe_n = dataOe_n[1];
endmodule
`default_nettype wire

/* hdl/emio_module_end.sv */
// Plug-on module end of one expansion connector
`timescale 1ns/100ps
`default_nettype none
`include "emio_params.svh"
module emio_module_end #(
    parameter bit WIDE     = 1'b1,
    parameter int WAIT_LAT = `EMIO_WAIT_LAT
) (
    emio_link_if.module_end link,
    input  wire logic [1:0]  irqIn,
    input  wire logic [1:0]  optIn,
    output logic      [15:0] lastWrite
);
    // ****************************************
    // Reset from the link, released on mclk
    // ****************************************
    logic [1:0] rstPipe;
    logic       rst;
    always_ff @(posedge link.mclk or posedge link.mreset) begin
        if (link.mreset) begin
            rstPipe <= 2'b11;
        end else begin
            rstPipe <= {rstPipe[0], 1'b0};
        end
    end
    assign rst = rstPipe[1]; // [RULE_09]

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [22:0] syncA;
    logic [22:0] syncB;
    always_ff @(posedge link.mclk or posedge rst) begin
        if (rst) begin
            syncA <= {7'h7F, 16'h0000};
            syncB <= {7'h7F, 16'h0000};
        end else begin
            syncA <= {link.select_n, link.readCmd_n, link.writeCmd_n,
                      link.addrLines, link.dataBus};
            syncB <= syncA;
        end
    end
    logic [1:0]  selS_n;
    logic        rdS_n;
    logic        wrS_n;
    logic [2:0]  addrS;
    logic [15:0] dataS;
    assign {selS_n, rdS_n, wrS_n, addrS, dataS} = syncB;

    logic active;
    logic activeQ;
    assign active = (~&selS_n) & (~rdS_n | ~wrS_n); // [RULE_08]
    always_ff @(posedge link.mclk or posedge rst) begin
        if (rst) begin
            activeQ <= 1'b0;
        end else begin
            activeQ <= active;
        end
    end

    // ****************************************
    // Wait request and register storage
    // ****************************************
    logic [15:0]           regs [0:15];
    logic [`EMIO_CNT_W-1:0] waitCnt;
    logic                   waitReq_n;
    logic [3:0]             idx;
    assign idx = {selS_n[0], addrS};

    always_ff @(posedge link.mclk or posedge rst) begin
        if (rst) begin
            waitCnt   <= '0;
            waitReq_n <= 1'b1;
        end else if (active && !activeQ) begin
            waitCnt   <= `EMIO_CNT_W'(WAIT_LAT);
            waitReq_n <= 1'b0; // [RULE_12]
        end else if (waitCnt != '0) begin
            waitCnt   <= waitCnt - 1'b1;
            waitReq_n <= (waitCnt == `EMIO_CNT_W'(1));
        end
    end

    always_ff @(posedge link.mclk or posedge rst) begin
        if (rst) begin
            lastWrite <= 16'h0000;
        end else if (!wrS_n && (~&selS_n) && waitCnt == `EMIO_CNT_W'(1)) begin
            lastWrite <= WIDE ? dataS : {8'h00, dataS[7:0]}; // [RULE_15]
        end
    end

    always_ff @(posedge link.mclk) begin
        if (!wrS_n && (~&selS_n) && waitCnt == `EMIO_CNT_W'(1)) begin
            regs[idx] <= WIDE ? dataS : {8'h00, dataS[7:0]};
        end
    end

    // ****************************************
    // Link outputs
    // ****************************************
    logic [15:0] modData;
    logic [1:0]  modOe_n;
    logic [1:0]  irqQ;
    logic [1:0]  optQ;
    always_ff @(posedge link.mclk or posedge rst) begin
        if (rst) begin
            modData <= 16'h0000;
            modOe_n <= 2'b11;
            irqQ    <= 2'b00;
            optQ    <= 2'b00;
        end else begin
            modData <= regs[idx];
            modOe_n <= (!rdS_n && (~&selS_n)) ? {~WIDE, 1'b0} : 2'b11; // [RULE_16]
            irqQ    <= irqIn; // [RULE_11]
            optQ    <= optIn; // [RULE_14]
        end
    end
    assign link.modData     = modData;
    assign link.modDataOe_n = modOe_n;
    assign link.waitReq_n   = waitReq_n;
    assign link.present_n   = 1'b0; // [RULE_10]
    assign link.moduleIrq   = irqQ;
    assign link.optionLine  = optQ;
endmodule
`default_nettype wire

/* test/emio_link_asserts.sv */
// Checker of the first expansion link, host end against module end
`timescale 1ns/100ps
`default_nettype none
module emio_link_asserts (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        mclk,
    input wire logic        mreset,
    input wire logic [2:0]  addrLines,
    input wire logic [1:0]  select_n,
    input wire logic        readCmd_n,
    input wire logic        writeCmd_n,
    input wire logic [15:0] hostData,
    input wire logic        hostDataOe_n,
    input wire logic [1:0]  modDataOe_n,
    input wire logic        waitReq_n
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic [3:0] mclkIdle;
    logic       mclkLast;
    logic       anyCmd;

    assign anyCmd = !readCmd_n || !writeCmd_n;

    // Cycles since the module clock last changed
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mclkIdle <= 4'h0;
            mclkLast <= 1'b0;
        end else begin
            mclkLast <= mclk;
            mclkIdle <= (mclk != mclkLast) ? 4'h0 : mclkIdle + ((mclkIdle == 4'hF) ? 4'h0 : 4'h1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ****************************************
    // Properties
    // ****************************************
    property p_cmd_select; anyCmd |-> select_n != 2'b11 && (readCmd_n || writeCmd_n); endproperty
    a_cmd_select: assert property (p_cmd_select) else $error("command without one select");
    property p_host_oe; !hostDataOe_n |-> readCmd_n && modDataOe_n == 2'b11; endproperty
    a_host_oe: assert property (p_host_oe) else $error("host drives data outside a write");
    property p_mod_oe; $fell(modDataOe_n[0]) |-> !readCmd_n && select_n != 2'b11; endproperty
    a_mod_oe: assert property (p_mod_oe) else $error("module drives data without read");
    property p_mreset_hold; $rose(reset_n) |-> mreset [*8]; endproperty
    a_mreset_hold: assert property (p_mreset_hold) else $error("module reset too short");
    property p_quiet_reset; mreset |-> select_n == 2'b11 && !anyCmd; endproperty
    a_quiet_reset: assert property (p_quiet_reset) else $error("access during module reset");
    property p_mclk_period; $changed(mclk) |=> $stable(mclk) ##1 $changed(mclk); endproperty
    a_mclk_period: assert property (p_mclk_period) else $error("module clock period wrong");
    property p_mclk_run; mclkIdle < 4'h4; endproperty
    a_mclk_run: assert property (p_mclk_run) else $error("module clock stopped");
    property p_wait_hold; !waitReq_n && anyCmd |=> anyCmd; endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("command ended under wait");
    property p_addr_stable; anyCmd ##1 anyCmd |-> $stable(addrLines) && $stable(select_n); endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in command");
    property p_wdata_stable; !writeCmd_n ##1 !writeCmd_n |-> $stable(hostData); endproperty
    a_wdata_stable: assert property (p_wdata_stable) else $error("write data moved");
endmodule
`default_nettype wire

/* test/expansion_module_io_port_test.sv */
// Bench: host end joined to a 16-bit module end and an 8-bit module end
`timescale 1ns/100ps
`default_nettype none
module expansion_module_io_port_test;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clk_sys;
    logic        reset_n;
    logic        cpuReq;
    logic        cpuWrite;
    logic [7:0]  cpuAddr;
    logic [15:0] cpuWdata;
    logic [1:0]  connWide;
    logic [1:0]  optIrqEn;
    logic [1:0]  irqIn1;
    logic [1:0]  optIn1;
    logic [1:0]  irqIn2;
    logic [1:0]  optIn2;
    logic        cpuBusy;
    logic        cpuAck;
    logic        cpuMiss;
    logic [15:0] cpuRdata;
    logic [7:0]  irqMatrix;
    logic [1:0]  modulePresent;
    logic [15:0] lastWrite1;
    logic [15:0] lastWrite2;
    logic [1:0]  sel1Seen;
    logic [1:0]  sel2Seen;
    logic [2:0]  addrSeen;
    logic        waitSeen;
    logic        missSeen;
    int          badCount;
    int          testsRun;
    int          cycles;

    emio_link_if link1If ();
    emio_link_if link2If ();

    emio_host_end u_emio_host_end (
        .clk_sys(clk_sys), .reset_n(reset_n), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
        .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .connWide(connWide), .optIrqEn(optIrqEn),
        .cpuBusy(cpuBusy), .cpuAck(cpuAck), .cpuMiss(cpuMiss), .cpuRdata(cpuRdata),
        .irqMatrix(irqMatrix), .modulePresent(modulePresent), .link1(link1If), .link2(link2If)
    );
    emio_module_end #(.WIDE(1'b1)) u_emio_module_end1 (
        .link(link1If), .irqIn(irqIn1), .optIn(optIn1), .lastWrite(lastWrite1)
    );
    emio_module_end #(.WIDE(1'b0)) u_emio_module_end2 (
        .link(link2If), .irqIn(irqIn2), .optIn(optIn2), .lastWrite(lastWrite2)
    );
    emio_link_asserts u_emio_link_asserts (
        .clk_sys(clk_sys), .reset_n(reset_n), .mclk(link1If.mclk), .mreset(link1If.mreset),
        .addrLines(link1If.addrLines), .select_n(link1If.select_n),
        .readCmd_n(link1If.readCmd_n), .writeCmd_n(link1If.writeCmd_n),
        .hostData(link1If.hostData), .hostDataOe_n(link1If.hostDataOe_n),
        .modDataOe_n(link1If.modDataOe_n), .waitReq_n(link1If.waitReq_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One CPU access; records what both links showed until the acknowledge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data);
        int n;
        n = 0;
        sel1Seen = 2'b11;
        sel2Seen = 2'b11;
        waitSeen = 1'b0;
        @(negedge clk_sys);
        cpuReq = 1'b1;
        cpuWrite = wr;
        cpuAddr = addr;
        cpuWdata = data;
        @(negedge clk_sys);
        cpuReq = 1'b0;
        while (cpuAck !== 1'b1 && n < 600) begin
            sel1Seen &= link1If.select_n;
            sel2Seen &= link2If.select_n;
            if (link1If.select_n != 2'b11) addrSeen = link1If.addrLines;
            if (link2If.select_n != 2'b11) addrSeen = link2If.addrLines;
            waitSeen |= !(link1If.waitReq_n && link2If.waitReq_n);
            @(negedge clk_sys);
            n++;
        end
        missSeen = cpuMiss;
        check({15'h0000, cpuAck}, 16'h0001);
        check({14'h0000, link1If.waitReq_n, link2If.waitReq_n}, 16'h0003);
    endtask

    task automatic decode(input logic [1:0] wide, input logic [7:0] addr,
                          input logic [1:0] exp1, input logic [1:0] exp2, input logic miss);
        connWide = wide;
        access(1'b1, addr, 16'h3CC3);
        check({14'h0000, sel1Seen}, {14'h0000, exp1});
        check({14'h0000, sel2Seen}, {14'h0000, exp2});
        check({15'h0000, missSeen}, {15'h0000, miss});
        check({15'h0000, waitSeen}, {15'h0000, ~miss});
        if (!miss) check({13'h0000, addrSeen}, {13'h0000, addr[3:1]});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testReset();
        logic [15:0] acks;
        int n;
        acks = 16'h0000;
        n = 0;
        @(negedge clk_sys);
        reset_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        check({15'h0000, link1If.mreset}, 16'h0001);
        repeat (10) @(negedge clk_sys);
        cpuReq = 1'b1;
        cpuWrite = 1'b1;
        cpuAddr = 8'hA4;
        @(negedge clk_sys);
        cpuReq = 1'b0;
        repeat (20) begin
            @(negedge clk_sys);
            if (cpuAck !== 1'b0 || cpuBusy !== 1'b0) acks++;
        end
        check(acks, 16'h0000);
        while (link1If.mreset !== 1'b0 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (8) @(negedge clk_sys);
        check(lastWrite1, 16'h0000);
        $display("test reset done");
    endtask

    task automatic testDecode();
        decode(2'b00, 8'h84, 2'b01, 2'b10, 1'b0);
        decode(2'b11, 8'h8E, 2'b11, 2'b10, 1'b0);
        decode(2'b01, 8'h80, 2'b11, 2'b10, 1'b0);
        decode(2'b00, 8'hA2, 2'b10, 2'b11, 1'b0);
        decode(2'b00, 8'h96, 2'b11, 2'b01, 1'b0);
        decode(2'b10, 8'h9C, 2'b11, 2'b11, 1'b1);
        decode(2'b10, 8'h83, 2'b11, 2'b01, 1'b0);
        decode(2'b00, 8'h8F, 2'b11, 2'b11, 1'b1);
        decode(2'b01, 8'hAD, 2'b01, 2'b11, 1'b0);
        decode(2'b00, 8'hA1, 2'b11, 2'b11, 1'b1);
        decode(2'b00, 8'h7E, 2'b11, 2'b11, 1'b1);
        decode(2'b00, 8'hB0, 2'b11, 2'b11, 1'b1);
        $display("test decode done");
    endtask

    task automatic testData();
        connWide = 2'b01;
        access(1'b1, 8'hA4, 16'h5AA5);
        check(lastWrite1, 16'h5AA5);
        access(1'b1, 8'hA7, 16'hC33C);
        check(lastWrite1, 16'hC33C);
        access(1'b0, 8'hA4, 16'h0000);
        check(cpuRdata, 16'h5AA5);
        access(1'b0, 8'hA7, 16'h0000);
        check(cpuRdata, 16'hC33C);
        access(1'b1, 8'h96, 16'h12F0);
        check(lastWrite2, 16'h00F0);
        access(1'b0, 8'h96, 16'h0000);
        check({8'h00, cpuRdata[7:0]}, 16'h00F0);
        check({8'h00, cpuRdata[15:8]}, 16'h00FF);
        $display("test data done");
    endtask

    task automatic testIrq();
        optIrqEn = 2'b01;
        irqIn1 = 2'b10;
        optIn1 = 2'b11;
        irqIn2 = 2'b01;
        optIn2 = 2'b11;
        repeat (40) @(negedge clk_sys);
        check({8'h00, irqMatrix}, 16'h001E);
        optIrqEn = 2'b10;
        irqIn1 = 2'b01;
        optIn1 = 2'b10;
        irqIn2 = 2'b10;
        optIn2 = 2'b01;
        repeat (40) @(negedge clk_sys);
        check({8'h00, irqMatrix}, 16'h0061);
        check({14'h0000, modulePresent}, 16'h0003);
        $display("test interrupts done");
    endtask

    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            printVerdict();
        end
    end

    initial begin
        {reset_n, cpuReq, cpuWrite, cpuAddr, cpuWdata} = '0;
        {connWide, optIrqEn, irqIn1, optIn1, irqIn2, optIn2} = '0;
        {badCount, testsRun, cycles} = '0;
        testReset();
        testDecode();
        testData();
        testIrq();
        testReset();
        printVerdict();
    end
endmodule
`default_nettype wire
